// >>> rtl/pfcu_flow.sv
// Purpose: program flow unit: jumps, calls, returns, interrupt gating, stop, halt
// Assumes: one instruction per clock while running, APB register access
// Notes:   stop only reports clock_stopped; the clock generator gates the clock
//
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`include "pfcu_cfg.svh"
`default_nettype none
module pfcu_flow
   import pfcu_pkg::*;
#(
   parameter int NIRQ  = 4,
   parameter int DEPTH = 5
) (
   input  wire logic        clk,
   input  wire logic        arst_n,
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic      [31:0] prdata,
   output logic             pslverr,
   input  wire logic        instr_valid,
   input  wire logic [15:0] instr,
   input  wire logic [3:0]  irq_pin,
   input  wire logic        wake_pin,
   output logic      [10:0] program_counter,
   output logic             skip_active,
   output logic             cpu_halted,
   output logic             clock_stopped,
   output logic             irq_taken
);
   localparam int PW = 11;
   localparam int SW = `PFCU_PSW_W;
   localparam int TW = `PFCU_TGT_W;
   localparam int AW = $clog2(DEPTH + 1);
   localparam int IW = $clog2(NIRQ);

   // lowest source number wins when several are pending
   function automatic logic [IW-1:0] pfcu_first(input logic [NIRQ-1:0] v);
      logic [IW-1:0] r;
      r = '0;
      for (int i = NIRQ - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = IW'(i);
         end
      end
      return r;
   endfunction

   function automatic logic [PW-1:0] pfcu_inc(input logic [PW-1:0] a);
      return a + PW'(1);
   endfunction

   logic [NIRQ-1:0] irq_meta;
   logic [NIRQ-1:0] irq_sync;
   logic [NIRQ-1:0] irq_prev;
   logic [NIRQ-1:0] irq_req;
   logic [NIRQ-1:0] src_en;
   logic            wake_meta;
   logic            wake_sync;
   logic            wake_prev;
   logic [TW-1:0]   target;
   logic [SW-1:0]   psw;
   logic            global_irq_enable;
   logic [3:0]      rel_cond;
   pfcu_state_t     state;
   pfcu_state_t     next_state;
   wire  [PW-1:0]   ret_top;
   wire  [AW-1:0]   sp;
   wire  [SW-1:0]   save_top;

   // ****************************************
   // pin synchronisers
   // ****************************************
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         irq_meta  <= '0;
         irq_sync  <= '0;
         irq_prev  <= '0;
         wake_meta <= 1'b0;
         wake_sync <= 1'b0;
         wake_prev <= 1'b0;
      end else begin
         irq_meta  <= irq_pin[NIRQ-1:0];
         irq_sync  <= irq_meta;
         irq_prev  <= irq_sync;
         wake_meta <= wake_pin;
         wake_sync <= wake_meta;
         wake_prev <= wake_sync;
      end
   end

   wire [NIRQ-1:0] irq_rise  = irq_sync & ~irq_prev;
   wire            wake_rise = wake_sync & ~wake_prev;

   // ****************************************
   // decode
   // ****************************************
   wire [4:0] f_op = instr[`PFCU_F_OP];
   wire [2:0] f_3  = instr[`PFCU_F_3];
   wire [3:0] f_4  = instr[`PFCU_F_4];
   wire [3:0] f_0  = instr[`PFCU_F_0];
   wire sys   = f_op == `PFCU_OP_SYS;
   wire z0    = f_0 == `PFCU_F0_ZERO;
   wire is_jmp    = f_op == `PFCU_OP_JMP;
   wire is_call   = f_op == `PFCU_OP_CALL;
   wire is_brar   = sys & (f_3 == `PFCU_F3_A) & (f_4 == `PFCU_F4_BRAR) & z0;
   wire is_callar = sys & (f_3 == `PFCU_F3_A) & (f_4 == `PFCU_F4_CALLAR) & z0;
   wire is_ret    = sys & (f_3 == `PFCU_F3_A) & (f_4 == `PFCU_F4_EXIT) & z0;
   wire is_exit_and_skip  = sys & (f_3 == `PFCU_F3_B) & (f_4 == `PFCU_F4_EXIT) & z0;
   wire is_interrupt_exit   = sys & (f_3 == `PFCU_F3_C) & (f_4 == `PFCU_F4_EXIT) & z0;
   wire is_ei     = sys & (f_3 == `PFCU_F3_A) & (f_4 == `PFCU_F4_CTL) & z0;
   wire is_di     = sys & (f_3 == `PFCU_F3_B) & (f_4 == `PFCU_F4_CTL) & z0;
   wire is_stop   = sys & (f_3 == `PFCU_F3_STOP) & (f_4 == `PFCU_F4_CTL);
   wire is_halt   = sys & (f_3 == `PFCU_F3_HALT) & (f_4 == `PFCU_F4_CTL);
   wire is_nop    = sys & (f_3 == `PFCU_F3_C) & (f_4 == `PFCU_F4_CTL) & z0;
   wire flow_mod  = is_jmp | is_call | is_brar | is_callar | is_ret | is_exit_and_skip | is_interrupt_exit;

   // a skipped instruction still takes its cycle but changes nothing else
   wire advance = instr_valid & (state == PFCU_RUN);
   wire exec    = advance & ~skip_active;

   // ****************************************
   // interrupt acceptance
   // ****************************************
   wire [NIRQ-1:0] pend     = irq_req & src_en;
   // irq-off must also shut the gate at its own edge, or an entry slips in after it
   wire            irq_open = global_irq_enable & ~(exec & (is_ei | is_di));
   wire            take_irq = advance & irq_open & (|pend)
                              & ~(exec & (flow_mod | is_stop | is_halt));
   wire [IW-1:0]   irq_idx  = pfcu_first(pend);
   wire [PW-1:0]   vector   = `PFCU_VEC_BASE + PW'(irq_idx);
   wire [NIRQ-1:0] irq_ack  = take_irq ? (NIRQ'(1) << irq_idx) : '0;

   // ****************************************
   // program counter and stacks
   // ****************************************
   wire [PW-1:0] pc_inc    = pfcu_inc(program_counter);
   wire [PW-1:0] target_pc = PW'(target);
   wire          push_ret  = (exec & (is_call | is_callar)) | take_irq;
   wire          pop_ret   = exec & (is_ret | is_exit_and_skip | is_interrupt_exit);
   wire [PW-1:0] next_pc   =
      take_irq                        ? vector              :
      (exec & (is_jmp | is_call))     ? instr[`PFCU_F_ADDR] :
      (exec & (is_brar | is_callar))  ? target_pc           :
      pop_ret                         ? ret_top             :
      advance                         ? pc_inc              : program_counter;

   pfcu_stack #(
      .DW    (PW),
      .DEPTH (DEPTH),
      .AW    (AW)
   ) u_ret (
      .clk    (clk),
      .arst_n (arst_n),
      .push   (push_ret),
      .pop    (pop_ret),
      .wdata  (pc_inc),
      .top    (ret_top),
      .sp     (sp)
   );

   // status save stack follows interrupts only, not plain calls
   pfcu_stack #(
      .DW    (SW),
      .DEPTH (DEPTH),
      .AW    (AW)
   ) u_save (
      .clk    (clk),
      .arst_n (arst_n),
      .push   (take_irq),
      .pop    (exec & is_interrupt_exit),
      .wdata  (psw),
      .top    (save_top),
      .sp     ()
   );

   // ****************************************
   // apb slave
   // ****************************************
   wire apb_setup = psel & penable & ~pready;
   wire apb_wr    = psel & penable & pready & pwrite;
   wire hit_ctrl  = paddr == `PFCU_REG_CTRL;
   wire hit_tgt   = paddr == `PFCU_REG_TGT;
   wire hit_psw   = paddr == `PFCU_REG_PSW;
   wire hit_en    = paddr == `PFCU_REG_EN;
   wire hit_req   = paddr == `PFCU_REG_REQ;
   wire hit_stat  = paddr == `PFCU_REG_STAT;
   wire mapped    = hit_ctrl | hit_tgt | hit_psw | hit_en | hit_req | hit_stat;
   wire [31:0] rd_mux =
      hit_ctrl ? 32'(global_irq_enable) :
      hit_tgt  ? 32'(target)            :
      hit_psw  ? 32'(psw)               :
      hit_en   ? 32'(src_en)            :
      hit_req  ? 32'(irq_req)           :
      hit_stat ? 32'({state, 1'b0, sp, 1'b0, program_counter}) : 32'h0000_0000;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready  <= apb_setup;
         prdata  <= (apb_setup & ~pwrite) ? rd_mux : prdata;
         pslverr <= apb_setup & ~mapped;
      end
   end

   // ****************************************
   // flags and control state
   // ****************************************
   // write-one-to-clear loses against a request edge in the same cycle
   wire [NIRQ-1:0] req_clr  = (apb_wr & hit_req) ? pwdata[NIRQ-1:0] : '0;
   wire [NIRQ-1:0] next_req = (irq_req & ~(req_clr | irq_ack)) | irq_rise;
   wire next_gie =
      (exec & is_ei)             ? 1'b1 :
      ((exec & is_di) | take_irq) ? 1'b0 :
      (apb_wr & hit_ctrl)        ? pwdata[`PFCU_CTRL_GIE] : global_irq_enable;
   wire [SW-1:0] next_psw =
      (exec & is_interrupt_exit)   ? save_top :
      (apb_wr & hit_psw) ? pwdata[SW-1:0] : psw;
   wire release_now = (|(rel_cond[NIRQ-1:0] & irq_req)) | wake_rise;

   always_comb begin
      next_state = state;
      unique case (state)
         PFCU_RUN: begin
            if (exec & is_stop) begin
               next_state = PFCU_STOP;
            end else if (exec & is_halt) begin
               next_state = PFCU_HALT;
            end
         end
         PFCU_HALT, PFCU_STOP: begin
            if (release_now) begin
               next_state = PFCU_RUN;
            end
         end
         default: begin
            next_state = PFCU_RUN;
         end
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         program_counter   <= `PFCU_PC_RST;
         skip_active       <= 1'b0;
         global_irq_enable <= 1'b0;
         psw               <= `PFCU_PSW_RST;
         irq_req           <= '0;
         irq_taken         <= 1'b0;
      end else begin
         program_counter   <= next_pc;
         skip_active       <= advance ? (exec & is_exit_and_skip) : skip_active;
         global_irq_enable <= next_gie;
         psw               <= next_psw;
         irq_req           <= next_req;
         irq_taken         <= take_irq;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state         <= PFCU_RUN;
         cpu_halted    <= 1'b0;
         clock_stopped <= 1'b0;
         rel_cond      <= 4'h0;
      end else begin
         state         <= next_state;
         cpu_halted    <= next_state != PFCU_RUN;
         clock_stopped <= next_state == PFCU_STOP;
         rel_cond      <= (exec & (is_stop | is_halt)) ? f_0 : rel_cond;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         target <= '0;
         src_en <= '0;
      end else begin
         target <= (apb_wr & hit_tgt) ? pwdata[TW-1:0] : target;
         src_en <= (apb_wr & hit_en) ? pwdata[NIRQ-1:0] : src_en;
      end
   end

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);

   sequence s_stop_cmd;
      exec && is_stop;
   endsequence
   sequence s_stopped;
      clock_stopped && cpu_halted && !advance;
   endsequence

   property p_brar;
      exec && is_brar |=> program_counter == $past(target_pc);
   endproperty
   a_brar: assert property (p_brar)
      else $error("indirect jump went to a wrong address");
   property p_tgt_hi;
      apb_setup && !pwrite && hit_tgt |=> pready && prdata[31:10] == 22'h000000;
   endproperty
   a_tgt_hi: assert property (p_tgt_hi)
      else $error("target upper bits not zero");
   property p_call;
      exec && is_call |=> program_counter == $past(instr[`PFCU_F_ADDR])
         && sp == $past(sp) - AW'(1) && ret_top == $past(pc_inc);
   endproperty
   a_call: assert property (p_call)
      else $error("direct call wrong");
   property p_callar;
      exec && is_callar |=> program_counter == $past(target_pc)
         && ret_top == $past(pc_inc);
   endproperty
   a_callar: assert property (p_callar)
      else $error("indirect call wrong");
   property p_ret;
      exec && is_ret |=> program_counter == $past(ret_top) && sp == $past(sp) + AW'(1);
   endproperty
   a_ret: assert property (p_ret)
      else $error("return wrong");
   sequence s_skip_step;
      skip_active && advance && !take_irq;
   endsequence
   property p_exit_and_skip;
      exec && is_exit_and_skip |=> skip_active && program_counter == $past(ret_top);
   endproperty
   a_exit_and_skip: assert property (p_exit_and_skip)
      else $error("return-and-skip did not arm the skip");
   property p_skip;
      s_skip_step |=> !skip_active && program_counter == $past(pc_inc) && $stable(sp);
   endproperty
   a_skip: assert property (p_skip)
      else $error("skipped instruction not idle");
   property p_interrupt_exit;
      exec && is_interrupt_exit |=> psw == $past(save_top) && program_counter == $past(ret_top);
   endproperty
   a_interrupt_exit: assert property (p_interrupt_exit)
      else $error("interrupt exit did not restore");
   property p_save;
      take_irq |=> save_top == $past(psw);
   endproperty
   a_save: assert property (p_save)
      else $error("status not saved");
   property p_ei;
      exec && is_ei |-> !take_irq ##1 global_irq_enable;
   endproperty
   a_ei: assert property (p_ei)
      else $error("irq-on timing wrong");
   property p_pend;
      |irq_rise |=> (irq_req & $past(irq_rise)) == $past(irq_rise);
   endproperty
   a_pend: assert property (p_pend)
      else $error("request edge lost");
   property p_irq;
      take_irq |-> !(exec && flow_mod) ##1 irq_taken
         && program_counter == $past(vector) && ret_top == $past(pc_inc);
   endproperty
   a_irq: assert property (p_irq)
      else $error("interrupt entry wrong");
   property p_di;
      exec && is_di |-> !take_irq ##1 !global_irq_enable && !take_irq;
   endproperty
   a_di: assert property (p_di)
      else $error("irq-off ignored");
   property p_stop;
      s_stop_cmd |=> s_stopped;
   endproperty
   a_stop: assert property (p_stop)
      else $error("stop not entered");
   property p_halt;
      exec && is_halt ##1 !release_now |=> cpu_halted && !clock_stopped && !advance;
   endproperty
   a_halt: assert property (p_halt)
      else $error("halt not held");
   property p_nop;
      exec && is_nop && !take_irq |=> program_counter == $past(pc_inc)
         && $stable(sp) && $stable(psw) && $stable(global_irq_enable);
   endproperty
   a_nop: assert property (p_nop)
      else $error("idle op changed state");
endmodule
`default_nettype wire

// >>> rtl/pfcu_cfg.svh
// Purpose: constants of the program flow control unit
// Assumes: 16-bit instruction words, 32-bit APB slave, byte addresses
// Notes:   definitions only
`ifndef PFCU_CFG_SVH
`define PFCU_CFG_SVH

// ****************************************
// instruction fields
// ****************************************
`define PFCU_F_OP      15:11
`define PFCU_F_3       10:8
`define PFCU_F_4       7:4
`define PFCU_F_0       3:0
`define PFCU_F_ADDR    10:0
`define PFCU_OP_SYS    5'h07
`define PFCU_OP_JMP    5'h0C
`define PFCU_OP_CALL   5'h1C
`define PFCU_F3_A      3'h0
`define PFCU_F3_B      3'h1
`define PFCU_F3_STOP   3'h2
`define PFCU_F3_HALT   3'h3
`define PFCU_F3_C      3'h4
`define PFCU_F4_BRAR   4'h4
`define PFCU_F4_CALLAR 4'h5
`define PFCU_F4_EXIT   4'hE
`define PFCU_F4_CTL    4'hF
`define PFCU_F0_ZERO   4'h0

// ****************************************
// register map and reset values
// ****************************************
`define PFCU_REG_CTRL  8'h00
`define PFCU_REG_TGT   8'h04
`define PFCU_REG_PSW   8'h08
`define PFCU_REG_EN    8'h0C
`define PFCU_REG_REQ   8'h10
`define PFCU_REG_STAT  8'h14
`define PFCU_CTRL_GIE  0
`define PFCU_PC_RST    11'h000
`define PFCU_PSW_RST   4'h0
`define PFCU_VEC_BASE  11'h004
`define PFCU_TGT_W     10
`define PFCU_PSW_W     4

`endif

// >>> rtl/pfcu_pkg.sv
// Purpose: types of the program flow control unit
// Assumes: nothing
// Notes:   gray codes along run -> halt and run -> stop
`default_nettype none
package pfcu_pkg;
   typedef enum logic [1:0] {
      PFCU_RUN  = 2'h0,
      PFCU_HALT = 2'h1,
      PFCU_STOP = 2'h2
   } pfcu_state_t;
endpackage
`default_nettype wire

// >>> rtl/pfcu_stack.sv
// Purpose: descending stack, pointer decremented before a push
// Assumes: push and pop never in the same cycle
// Notes:   overflow is not flagged; a push beyond depth writes nothing but still moves the pointer
`include "pfcu_cfg.svh"
`default_nettype none
module pfcu_stack #(
   parameter int DW    = 11,
   parameter int DEPTH = 5,
   parameter int AW    = 3
) (
   input  wire logic          clk,
   input  wire logic          arst_n,
   input  wire logic          push,
   input  wire logic          pop,
   input  wire logic [DW-1:0] wdata,
   output logic      [DW-1:0] top,
   output logic      [AW-1:0] sp
);
   logic [DW-1:0] mem [DEPTH];
   wire  [AW-1:0] sp_dec = sp - AW'(1);
   wire  [AW-1:0] sp_inc = sp + AW'(1);
   wire           in_rng = sp < AW'(DEPTH);
   wire           wr_ok  = sp_dec < AW'(DEPTH);

   // empty stack reads zero rather than an undefined entry
   assign top = in_rng ? mem[sp] : '0;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sp <= AW'(DEPTH);
      end else if (push) begin
         sp <= sp_dec;
      end else if (pop) begin
         sp <= sp_inc;
      end
   end

   always_ff @(posedge clk) begin
      if (push && wr_ok) begin
         mem[sp_dec] <= wdata;
      end
   end
endmodule
`default_nettype wire

// >>> sim/tb_top.sv
// Purpose: self-checking bench of the program flow control unit
// Assumes: one instruction every two cycles, APB reads with one wait state
// Notes:   the driver queues expected pc and read data; monitors pop and compare
`include "pfcu_cfg.svh"
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;

   // ****************************************
   // signals and bench state
   // ****************************************
   logic        clk         = 1'b0;
   logic        arst_n      = 1'b0;
   logic [7:0]  paddr       = 8'h00;
   logic        psel        = 1'b0;
   logic        penable     = 1'b0;
   logic        pwrite      = 1'b0;
   logic [31:0] pwdata      = 32'h0;
   logic        instr_valid = 1'b0;
   logic [15:0] instr       = 16'h0;
   logic [3:0]  irq_pin     = 4'h0;
   logic        wake_pin    = 1'b0;
   logic        pready;
   logic [31:0] prdata;
   logic        pslverr;
   logic [10:0] program_counter;
   logic        skip_active;
   logic        cpu_halted;
   logic        clock_stopped;
   logic        irq_taken;
   int          num_errors  = 0;
   int          check_count = 0;
   int          irq_cnt     = 0;
   logic [10:0] pc          = 11'h000;
   logic [32:0] rd_q[$];
   logic [10:0] pc_q[$];

   localparam logic [15:0] OP_IDLE = {5'h07, 3'h4, 4'hF, 4'h0};
   localparam logic [15:0] OP_ION  = {5'h07, 3'h0, 4'hF, 4'h0};
   localparam logic [15:0] OP_IOFF = {5'h07, 3'h1, 4'hF, 4'h0};

   pfcu_flow pfcu_flow_inst (
      .clk(clk), .arst_n(arst_n), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .instr_valid(instr_valid), .instr(instr), .irq_pin(irq_pin),
      .wake_pin(wake_pin), .program_counter(program_counter), .skip_active(skip_active),
      .cpu_halted(cpu_halted), .clock_stopped(clock_stopped), .irq_taken(irq_taken)
   );

   always #50 clk = ~clk;

   // ****************************************
   // report and compare
   // ****************************************
   task automatic complete_run();
      $display("comparisons %0d, mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic tally(input logic ok, input logic [32:0] got, input logic [32:0] exp);
      check_count++;
      if (!ok) begin
         num_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_rd(input logic [32:0] got, input logic [32:0] exp);
      tally(got === exp, got, exp);
   endtask
   task automatic chk_pc(input logic [10:0] got, input logic [10:0] exp);
      tally(got === exp, 33'(got), 33'(exp));
   endtask
   task automatic chk_flag(input logic got, input logic exp);
      tally(got === exp, 33'(got), 33'(exp));
   endtask

   // status word: mode [17:16], stack pointer [14:12], pc [10:0]; bit 32 is pslverr
   function automatic logic [32:0] stat(input logic [1:0] m, input logic [2:0] sp);
      return {15'h0, m, 1'b0, sp, 1'b0, pc};
   endfunction

   // ****************************************
   // drivers
   // ****************************************
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int i;
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      for (i = 0; i < 16; i++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      if (i == 16) begin
         num_errors++;
         complete_run();
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [32:0] e);
      rd_q.push_back(e);
      apb(a, 1'b0, 32'h0);
   endtask

   // a gap cycle keeps the valid strobe from being driven twice in one step
   task automatic exec(input logic [15:0] w, input logic [10:0] nxt);
      pc_q.push_back(nxt);
      pc = nxt;
      instr <= w;
      instr_valid <= 1'b1;
      @(posedge clk);
      instr_valid <= 1'b0;
      @(posedge clk);
   endtask

   // pins pass a two-stage synchroniser, so hold them well past it
   task automatic pulse(input logic [3:0] irq, input logic wk);
      irq_pin <= irq;
      wake_pin <= wk;
      repeat (5) @(posedge clk);
      irq_pin <= 4'h0;
      wake_pin <= 1'b0;
      repeat (5) @(posedge clk);
   endtask

   task automatic wait_mode(input logic h, input logic s);
      int i;
      for (i = 0; i < 20; i++) begin
         @(posedge clk);
         if (cpu_halted === h && clock_stopped === s) break;
      end
      if (i == 20) begin
         num_errors++;
         complete_run();
      end
   endtask

   task automatic done_test(input string s);
      $display("test %s done", s);
   endtask

   // ****************************************
   // monitors
   // ****************************************
   always @(posedge clk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         chk_rd({pslverr, prdata}, rd_q.pop_front());
      end
      if (irq_taken === 1'b1) begin
         irq_cnt++;
      end
   end

   always @(posedge clk) begin
      if (instr_valid && cpu_halted === 1'b0) begin
         #1;
         chk_pc(program_counter, pc_q.pop_front());
      end
   end

   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      complete_run();
   end

   // ****************************************
   // scenarios
   // ****************************************
   initial begin
      logic [31:0] r;
      logic [10:0] a;
      logic [10:0] ret;
      int          n0;
      void'($urandom(78602));
      repeat (6) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      for (int k = 0; k < 5; k++) rd(8'(4 * k), 33'h0);
      rd(`PFCU_REG_STAT, stat(2'h0, 3'h5));
      apb(`PFCU_REG_STAT, 1'b1, 32'hFFFFFFFF);
      rd(`PFCU_REG_STAT, stat(2'h0, 3'h5));
      rd(8'h18, 33'h1_0000_0000);
      done_test("registers");
      for (int k = 0; k < 2; k++) begin
         r = (k == 0) ? 32'hFFFFFFFF : $urandom;
         apb(`PFCU_REG_TGT, 1'b1, r);
         rd(`PFCU_REG_TGT, {23'h0, r[9:0]});
         exec({5'h07, 3'h0, 4'h4, 4'h0}, {1'b0, r[9:0]});
      end
      done_test("indirect jump");
      a = 11'($urandom);
      ret = pc + 11'h1;
      exec({`PFCU_OP_CALL, a}, a);
      rd(`PFCU_REG_STAT, stat(2'h0, 3'h4));
      exec({5'h07, 3'h0, 4'hE, 4'h0}, ret);
      rd(`PFCU_REG_STAT, stat(2'h0, 3'h5));
      done_test("call and return");
      apb(`PFCU_REG_TGT, 1'b1, 32'h0000_0155);
      ret = pc + 11'h1;
      exec({5'h07, 3'h0, 4'h5, 4'h0}, 11'h155);
      exec(OP_IDLE, 11'h156);
      exec({5'h07, 3'h1, 4'hE, 4'h0}, ret);
      chk_flag(skip_active, 1'b1);
      exec({`PFCU_OP_CALL, 11'h7FF}, ret + 11'h1);
      chk_flag(skip_active, 1'b0);
      rd(`PFCU_REG_STAT, stat(2'h0, 3'h5));
      done_test("return and skip");
      apb(`PFCU_REG_PSW, 1'b1, 32'h0000_000A);
      apb(`PFCU_REG_EN, 1'b1, 32'h0000_0002);
      pulse(4'h2, 1'b0);
      rd(`PFCU_REG_REQ, 33'h2);
      n0 = irq_cnt;
      exec(OP_IDLE, pc + 11'h1);
      exec(OP_ION, pc + 11'h1);
      chk_flag(irq_cnt == n0, 1'b1);
      a = 11'($urandom);
      exec({`PFCU_OP_JMP, a}, a);
      ret = pc + 11'h1;
      exec(OP_IDLE, 11'(`PFCU_VEC_BASE + 1));
      repeat (2) @(posedge clk);
      chk_flag(irq_cnt == n0 + 1, 1'b1);
      rd(`PFCU_REG_REQ, 33'h0);
      rd(`PFCU_REG_STAT, stat(2'h0, 3'h4));
      apb(`PFCU_REG_PSW, 1'b1, 32'h0000_0003);
      exec({5'h07, 3'h4, 4'hE, 4'h0}, ret);
      rd(`PFCU_REG_PSW, 33'hA);
      rd(`PFCU_REG_STAT, stat(2'h0, 3'h5));
      done_test("interrupt");
      apb(`PFCU_REG_EN, 1'b1, 32'h0000_0001);
      pulse(4'h1, 1'b0);
      apb(`PFCU_REG_CTRL, 1'b1, 32'h0000_0001);
      n0 = irq_cnt;
      exec(OP_IOFF, pc + 11'h1);
      exec(OP_IDLE, pc + 11'h1);
      chk_flag(irq_cnt == n0, 1'b1);
      rd(`PFCU_REG_CTRL, 33'h0);
      rd(`PFCU_REG_REQ, 33'h1);
      apb(`PFCU_REG_REQ, 1'b1, 32'h0000_0001);
      rd(`PFCU_REG_REQ, 33'h0);
      done_test("interrupt off");
      exec({5'h07, 3'h3, 4'hF, 4'h0}, pc + 11'h1);
      wait_mode(1'b1, 1'b0);
      rd(`PFCU_REG_STAT, stat(2'h1, 3'h5));
      pulse(4'h0, 1'b1);
      wait_mode(1'b0, 1'b0);
      exec({5'h07, 3'h2, 4'hF, 4'h4}, pc + 11'h1);
      wait_mode(1'b1, 1'b1);
      rd(`PFCU_REG_STAT, stat(2'h2, 3'h5));
      pulse(4'h4, 1'b0);
      wait_mode(1'b0, 1'b0);
      exec(OP_IDLE, pc + 11'h1);
      done_test("halt and stop");
      arst_n <= 1'b0;
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      pc = `PFCU_PC_RST;
      @(posedge clk);
      rd(`PFCU_REG_STAT, stat(2'h0, 3'h5));
      rd(`PFCU_REG_REQ, 33'h0);
      done_test("reset in run");
      repeat (4) @(posedge clk);
      complete_run();
   end
endmodule
`default_nettype wire
